// [test/eic_core_model.sv]
// behavioural cpu core facing the controller
`timescale 1ns/1ps
`default_nettype none
module eic_core_model (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic [3:0]  instr_len,
   input wire logic        stack_push,
   input wire logic        vec_fetch,
   input wire logic [15:0] vec_addr_q,
   input wire logic        handler_go_q,
   output var logic        instr_done,
   output var logic [15:0] pc_next,
   output var logic [15:0] vec_rd_data
);
   logic [3:0] cnt_q;
   logic       halt_q;
   // instruction length counter; core halts from push to handler start
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_q <= 4'h0;
         halt_q <= 1'b0;
         pc_next <= 16'h0100;
      end else begin
         if (stack_push) halt_q <= 1'b1;
         else if (handler_go_q) halt_q <= 1'b0;
         if (instr_done) begin
            cnt_q <= 4'h0;
            pc_next <= pc_next + 16'h0002;
         end else if (!halt_q && !stack_push) cnt_q <= cnt_q + 4'h1;
      end
   end
   assign instr_done = !sys_rst && !halt_q && !stack_push && (cnt_q + 4'h1 >= instr_len);
   // released bus shows the inverse pattern, not the last word
   assign vec_rd_data = vec_fetch ? {8'hC0, vec_addr_q[7:0]} : {8'h3F, ~vec_addr_q[7:0]};
endmodule // eic_core_model
`default_nettype wire

// [test/eic_ctrl_asserts.sv]
// checker for the exception sequence of the edge interrupt controller
`timescale 1ns/1ps
`default_nettype none
module eic_ctrl_asserts (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        instr_done,
   input wire logic [15:0] pc_next,
   input wire logic [15:0] vec_rd_data,
   input wire logic        exc_busy,
   input wire logic        stack_push,
   input wire logic [15:0] stack_pc_q,
   input wire logic [7:0]  stack_ccr_q,
   input wire logic        vec_fetch,
   input wire logic [15:0] vec_addr_q,
   input wire logic        handler_fetch,
   input wire logic [15:0] handler_addr_q,
   input wire logic        handler_go_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // sequence and pushed values
   // ----------------------------------------
   a_seq_state_counts: assert property ($rose(stack_push) |-> stack_push[*4] ##1 vec_fetch[*2] ##1 handler_fetch[*4] ##1 (exc_busy && !handler_fetch)[*4] ##1 handler_go_q)
      else $error("exception state counts wrong");
   a_push_after_instr: assert property ($rose(stack_push) |-> $past(instr_done) && !$past(psel))
      else $error("push not at instruction end");
   a_push_pc_value: assert property ($rose(stack_push) |-> stack_pc_q == $past(pc_next))
      else $error("pushed pc wrong");
   a_push_ccr_open: assert property ($rose(stack_push) |-> !stack_ccr_q[7])
      else $error("accepted while masked");
   a_push_held: assert property (stack_push && $past(stack_push) |-> $stable(stack_pc_q) && $stable(stack_ccr_q))
      else $error("pushed values moved");
   a_vec_in_range: assert property ($rose(vec_fetch) |-> !vec_addr_q[0] && vec_addr_q inside {[16'h0008:16'h002E]})
      else $error("vector address out of range");
   a_handler_from_vec: assert property ($rose(handler_fetch) |-> handler_addr_q == $past(vec_rd_data))
      else $error("handler address not from vector");
   a_go_one_cycle: assert property (handler_go_q |=> !handler_go_q && !stack_push)
      else $error("handler start not a pulse");
endmodule // eic_ctrl_asserts
bind eic_ctrl eic_ctrl_asserts u_chk (.sys_clk, .sys_rst, .psel, .instr_done, .pc_next,
   .vec_rd_data, .exc_busy, .stack_push, .stack_pc_q, .stack_ccr_q, .vec_fetch, .vec_addr_q,
   .handler_fetch, .handler_addr_q, .handler_go_q);
`default_nettype wire

// [test/testbench.sv]
// self-checking bench of the edge interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "eic_consts.vh"
module testbench;
   logic        sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, pin_group_line = 8'h0F;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  ext_req_line = 4'hF, instr_len = 4'h1;
   logic [4:0]  evt_q = 5'h00;
   logic        pready, pslverr, slv, instr_done, exc_busy, stack_push, vec_fetch;
   logic        handler_fetch, handler_go_q;
   logic [15:0] pc_next, vec_rd_data, stack_pc_q, vec_addr_q, handler_addr_q;
   logic [7:0]  stack_ccr_q;
   int          err_count = 0, checks = 0, i, n;
   logic [7:0]  en_t [5] = '{`EIC_OFS_EN_A, `EIC_OFS_EN_A, `EIC_OFS_EN_B, `EIC_OFS_EN_B, `EIC_OFS_EN_B};
   logic [7:0]  rq_t [5] = '{`EIC_OFS_REQ_A, `EIC_OFS_REQ_A, `EIC_OFS_REQ_B, `EIC_OFS_REQ_B, `EIC_OFS_REQ_B};
   logic [7:0]  bt_t [5] = '{8'h80, 8'h40, 8'h80, 8'h40, 8'h10};
   logic [15:0] va_t [5] = '{16'h001A, 16'h0018, 16'h0016, 16'h0014, 16'h0012};
   always #25 sys_clk = ~sys_clk;
   eic_ctrl dut (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .ext_req_line, .pin_group_line, .tmr_b1_evt(evt_q[4]), .tmr_a_evt(evt_q[3]),
      .dxfer_evt(evt_q[2]), .adc_evt(evt_q[1]), .serial_done_evt(evt_q[0]), .instr_done, .pc_next,
      .vec_rd_data, .exc_busy, .stack_push, .stack_pc_q, .stack_ccr_q, .vec_fetch, .vec_addr_q,
      .handler_fetch, .handler_addr_q, .handler_go_q);
   eic_core_model u_core (.sys_clk, .sys_rst, .instr_len, .stack_push, .vec_fetch, .vec_addr_q,
      .handler_go_q, .instr_done, .pc_next, .vec_rd_data);
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task end_sim;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // a used-up wait counts as a mismatch and ends the run
   task tmo;
      err_count++;
      $display("[FAIL] %0t wait ran out", $time);
      end_sim;
   endtask
   // apb transfer, entered just after a rising edge; no wait count assumed
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
      @(posedge sys_clk) penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      if (n == 16) tmo;
      rd = prdata; slv = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d); apb(1'b1, a, d); endtask
   task rchk(input logic [7:0] a, input logic [7:0] e); apb(1'b0, a, 8'h00); chk(rd, {24'h0, e}); endtask
   task pause(input int c); repeat (c) @(posedge sys_clk); endtask
   // wait for the vector fetch and handler start, then mask must be set
   task take(input logic [15:0] va);
      for (n = 0; n < 400 && vec_fetch !== 1'b1; n++) @(posedge sys_clk) #1;
      if (n == 400) tmo;
      chk({16'h0, vec_addr_q}, {16'h0, va});
      for (n = 0; n < 40 && handler_go_q !== 1'b1; n++) @(posedge sys_clk) #1;
      if (n == 40) tmo;
      chk({16'h0, handler_addr_q}, {16'h0, 8'hC0, va[7:0]});
      chk({24'h0, stack_ccr_q}, 32'h00000000);
      @(posedge sys_clk);
      rchk(`EIC_OFS_CCR, 8'h80);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      pause(2);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      rchk(`EIC_OFS_REQ_A, 8'h10); rchk(`EIC_OFS_REQ_B, 8'h00); rchk(`EIC_OFS_REQ_C, 8'h00);
      rchk(`EIC_OFS_EN_C, 8'h00); rchk(`EIC_OFS_CCR, 8'h80);
      apb(1'b0, 8'h2C, 8'h00); chk({31'h0, slv}, 32'h1); chk(rd, 32'h0);
      // pin group polarity, upper rising lower falling, port use
      wr(`EIC_OFS_EDGE_B, 8'hF0);
      pin_group_line <= 8'hF0; pause(5); rchk(`EIC_OFS_REQ_C, 8'hFF);
      wr(`EIC_OFS_REQ_C, 8'hFF); rchk(`EIC_OFS_REQ_C, 8'hFF);
      wr(`EIC_OFS_REQ_C, 8'h00); rchk(`EIC_OFS_REQ_C, 8'h00);
      pin_group_line <= 8'h0F; pause(5); rchk(`EIC_OFS_REQ_C, 8'h00);
      // request lines only flag in request mode
      wr(`EIC_OFS_EDGE_A, 8'h00); wr(`EIC_OFS_PMODE, 8'h05);
      ext_req_line <= 4'h0; pause(5); rchk(`EIC_OFS_REQ_A, 8'h15);
      wr(`EIC_OFS_REQ_A, 8'h00); wr(`EIC_OFS_PMODE, 8'h0F);
      ext_req_line <= 4'hF; pause(5); rchk(`EIC_OFS_REQ_A, 8'h10);
      ext_req_line <= 4'h5; pause(5); rchk(`EIC_OFS_REQ_A, 8'h1A);
      wr(`EIC_OFS_EN_A, 8'h08); pause(20); chk({31'h0, exc_busy}, 32'h0);
      instr_len <= 4'hD;
      wr(`EIC_OFS_CCR, 8'h00); take(16'h000E);
      rchk(`EIC_OFS_REQ_A, 8'h1A);
      wr(`EIC_OFS_EN_A, 8'h0A); wr(`EIC_OFS_CCR, 8'h00); take(16'h000A);
      instr_len <= 4'h1;
      // clear right after unmasking meets the pending request: nothing is taken
      wr(`EIC_OFS_CCR, 8'h00); wr(`EIC_OFS_REQ_A, 8'h00); pause(30);
      chk({31'h0, exc_busy}, 32'h0); rchk(`EIC_OFS_CCR, 8'h00);
      wr(`EIC_OFS_CCR, 8'h80);
      wr(`EIC_OFS_REQ_A, 8'h00); wr(`EIC_OFS_EN_A, 8'h00);
      // every internal source: flag, reserved bits, vector
      for (i = 0; i < 5; i++) begin
         wr(en_t[i], bt_t[i]);
         evt_q <= 5'h10 >> i;
         @(posedge sys_clk) evt_q <= 5'h00;
         wr(rq_t[i], 8'hFF);
         rchk(rq_t[i], bt_t[i] | (i < 2 ? 8'h10 : 8'h00));
         wr(`EIC_OFS_CCR, 8'h00); take(va_t[i]);
         wr(rq_t[i], 8'h00); wr(en_t[i], 8'h00);
      end
      // shared group vector outranks the serial request
      wr(`EIC_OFS_EN_C, 8'h01); wr(`EIC_OFS_EN_B, 8'h10);
      pin_group_line <= 8'h0E; evt_q <= 5'h01;
      @(posedge sys_clk) evt_q <= 5'h00;
      pause(5); wr(`EIC_OFS_CCR, 8'h00); take(16'h0010);
      wr(`EIC_OFS_REQ_C, 8'h00); wr(`EIC_OFS_CCR, 8'h00); take(16'h0012);
      end_sim;
   end
endmodule // testbench
`default_nettype wire

// [verilog/eic_consts.vh]
// constants of the edge interrupt controller
`ifndef EIC_CONSTS_VH
`define EIC_CONSTS_VH
// register byte offsets
`define EIC_OFS_EDGE_A   8'h00
`define EIC_OFS_EDGE_B   8'h04
`define EIC_OFS_EN_A     8'h08
`define EIC_OFS_EN_B     8'h0C
`define EIC_OFS_EN_C     8'h10
`define EIC_OFS_REQ_A    8'h14
`define EIC_OFS_REQ_B    8'h18
`define EIC_OFS_REQ_C    8'h1C
`define EIC_OFS_PMODE    8'h20
`define EIC_OFS_CCR      8'h24
`define EIC_OFS_STAT     8'h28
// field positions
`define EIC_BIT_TMR_B1   7
`define EIC_BIT_TMR_A    6
`define EIC_BIT_FIX1     4
`define EIC_BIT_DXFER    7
`define EIC_BIT_ADC      6
`define EIC_BIT_SER      4
`define EIC_BIT_GMASK    7
// reset values and writable masks
`define EIC_RST_REQ_A    8'h10
`define EIC_RST_ZERO     8'h00
`define EIC_RST_CCR      8'h80
`define EIC_MSK_A        8'hCF
`define EIC_MSK_B        8'hD0
// vector numbers
`define EIC_VEC_EXT0     5'h04
`define EIC_VEC_GRP      5'h08
`define EIC_VEC_SER      5'h09
`define EIC_VEC_ADC      5'h0A
`define EIC_VEC_DXFER    5'h0B
`define EIC_VEC_TMR_A    5'h0C
`define EIC_VEC_TMR_B1   5'h0D
// exception handling state counts
`define EIC_ST_SAVE      3'h4
`define EIC_ST_VEC       3'h2
`define EIC_ST_FETCH     3'h4
`define EIC_ST_INTERNAL  3'h4
`endif

// [verilog/eic_ctrl.v]
// edge interrupt controller with apb register file and exception sequencer
//
// Function
// R01: serial done sets bit 4, zero-write clears
// R02: reserved peripheral bits read zero, ignore writes
// R03: eight pin group flags, reset zero, edge-set
// R04: flags survive acceptance; only zero-write clears
// R05: twelve external sources, each flagged
// R06: per-line edge polarity select
// R07: request lines flag only in request mode
// R08: per-source enable bit blocks recognition
// R09: forward request only while enabled
// R10: global mask bit blocks all maskable
// R11: request lines vectors 7..4, line0 highest
// R12: all pin group lines share vector 8
// R13: pin group edges flag in port use
// R14: internal requests flag, vectors 23..9
// R15: pick highest priority, others stay pending
// R16: accept only with mask clear, else pend
// R17: after instruction, push pc and ccr
// R18: set global mask at exception start
// R19: fetch vector, run handler from it
// R20: software clears only while masked
// R21: clear collision: exception after clear completes
// R22: 1-13, 4 save, 2 vec, 4 fetch, 4 internal
// R23: pin group enables reset to zero
// R24: pins synchronised, edges from samples
// R25: lower vector number wins ties
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "eic_consts.vh"
module eic_ctrl (
   input  wire        sys_clk,
   input  wire        sys_rst,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // pins
   input  wire [3:0]  ext_req_line,
   input  wire [7:0]  pin_group_line,
   // internal peripheral events, one-cycle pulses
   input  wire        tmr_b1_evt,
   input  wire        tmr_a_evt,
   input  wire        dxfer_evt,
   input  wire        adc_evt,
   input  wire        serial_done_evt,
   // cpu core side
   input  wire        instr_done,
   input  wire [15:0] pc_next,
   input  wire [15:0] vec_rd_data,
   output wire        exc_busy,
   output wire        stack_push,
   output reg  [15:0] stack_pc_q,
   output reg  [7:0]  stack_ccr_q,
   output wire        vec_fetch,
   output reg  [15:0] vec_addr_q,
   output wire        handler_fetch,
   output reg  [15:0] handler_addr_q,
   output reg         handler_go_q
);

   // ------------------------------------------------------------
   // sequencer states
   // ------------------------------------------------------------
   localparam [5:0] S_IDLE  = 6'b000001;
   localparam [5:0] S_WAIT  = 6'b000010;
   localparam [5:0] S_SAVE  = 6'b000100;
   localparam [5:0] S_VEC   = 6'b001000;
   localparam [5:0] S_FETCH = 6'b010000;
   localparam [5:0] S_INT   = 6'b100000;

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // lowest set index wins, so lower vector numbers take priority
   function [4:0] top_vec;
      input [23:0] req_vec;
      integer i;
      begin
         top_vec = 5'h00;
         for (i = 23; i >= 0; i = i - 1) begin
            if (req_vec[i]) begin
               top_vec = i[4:0]; // R25
            end
         end
      end
   endfunction

   // edge on selected polarity: 1 rising, 0 falling
   function [7:0] edge_hit;
      input [7:0] cur;
      input [7:0] prev;
      input [7:0] pol;
      begin
         edge_hit = (pol & cur & ~prev) | (~pol & ~cur & prev);
      end
   endfunction

   // write strobe aimed at one offset; shared by the zero-write clears
   function wr_hit;
      input       w;
      input [7:0] a;
      input [7:0] ofs;
      begin
         wr_hit = w & (a == ofs);
      end
   endfunction

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg  [3:0]  edge_a_q;
   reg  [7:0]  edge_b_q;
   reg  [3:0]  en_ext_q;
   reg  [1:0]  en_tmr_q;
   reg  [7:0]  en_b_q;
   reg  [7:0]  en_c_q;
   reg  [7:0]  req_a_q;
   reg  [7:0]  req_b_q;
   reg  [7:0]  req_c_q;
   reg  [3:0]  pmode_q;
   reg  [7:0]  ccr_q;
   reg  [31:0] rdata_q;
   reg  [5:0]  state_q;
   reg  [2:0]  cnt_q;
   reg  [4:0]  vec_q;
   reg  [11:0] sync1_q;
   reg  [11:0] sync2_q;
   reg  [11:0] prev_q;

   wire        setup  = psel & ~penable;
   wire        access = psel & penable;
   wire        wr     = access & pwrite;
   wire [7:0]  wd     = pwdata[7:0];
   wire        mapped = (paddr <= `EIC_OFS_STAT) && (paddr[1:0] == 2'b00);

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   // zero wait states; read data latched in setup so it is a flop
   // limitation: only the low byte of each word carries data, save the status word (state in bits 13:8)
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;
   assign prdata  = rdata_q;

   // read mux sampled in the setup cycle
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         rdata_q <= 32'h00000000;
      end else if (setup) begin
         case (paddr)
            `EIC_OFS_EDGE_A: rdata_q <= {28'h0000000, edge_a_q};
            `EIC_OFS_EDGE_B: rdata_q <= {24'h000000, edge_b_q};
            `EIC_OFS_EN_A:   rdata_q <= {24'h000000, en_tmr_q, 2'b00, en_ext_q};
            `EIC_OFS_EN_B:   rdata_q <= {24'h000000, en_b_q};
            `EIC_OFS_EN_C:   rdata_q <= {24'h000000, en_c_q};
            `EIC_OFS_REQ_A:  rdata_q <= {24'h000000, req_a_q};
            `EIC_OFS_REQ_B:  rdata_q <= {24'h000000, req_b_q}; // R02
            `EIC_OFS_REQ_C:  rdata_q <= {24'h000000, req_c_q};
            `EIC_OFS_PMODE:  rdata_q <= {28'h0000000, pmode_q};
            `EIC_OFS_CCR:    rdata_q <= {24'h000000, ccr_q};
            `EIC_OFS_STAT:   rdata_q <= {18'h00000, state_q, 3'b000, vec_q};
            default:         rdata_q <= 32'h00000000;
         endcase
      end
   end

   // configuration registers
   // reserved enable bits stay zero, via the write mask for en_b_q and by not storing bits 5:4 of the a word
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         edge_a_q <= 4'h0;
         edge_b_q <= `EIC_RST_ZERO;
         en_ext_q <= 4'h0;
         en_tmr_q <= 2'b00;
         en_b_q   <= `EIC_RST_ZERO;
         en_c_q   <= `EIC_RST_ZERO; // R23
         pmode_q  <= 4'h0;
      end else if (wr) begin
         case (paddr)
            `EIC_OFS_EDGE_A: edge_a_q <= wd[3:0];
            `EIC_OFS_EDGE_B: edge_b_q <= wd;
            `EIC_OFS_EN_A: begin
               en_ext_q <= wd[3:0];
               en_tmr_q <= wd[7:6];
            end
            `EIC_OFS_EN_B:   en_b_q <= wd & `EIC_MSK_B;
            `EIC_OFS_EN_C:   en_c_q <= wd;
            `EIC_OFS_PMODE:  pmode_q <= wd[3:0];
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // pin synchronisers and edge detection
   // ------------------------------------------------------------
   // first stage feeds only the second stage
   // low reset level with falling default polarity: no flag right after reset
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         sync1_q <= 12'h000;
         sync2_q <= 12'h000;
         prev_q  <= 12'h000;
      end else begin
         sync1_q <= {pin_group_line, ext_req_line}; // R24
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   wire [7:0] ext_hit = edge_hit({4'h0, sync2_q[3:0]}, {4'h0, prev_q[3:0]},
                                 {4'h0, edge_a_q}); // R06
   // pin reads the pad level, so driven port edges count too
   wire [7:0] grp_hit = edge_hit(sync2_q[11:4], prev_q[11:4], edge_b_q); // R06 R13
   // a port-mode switch alone sets nothing; only a sampled edge does
   wire [3:0] ext_set = ext_hit[3:0] & pmode_q; // R07

   // ------------------------------------------------------------
   // request flags
   // ------------------------------------------------------------
   // set wins over a zero-write in the same cycle; ones are ignored
   wire [7:0] clr_a = wr_hit(wr, paddr, `EIC_OFS_REQ_A) ? (~wd & `EIC_MSK_A) : 8'h00;
   wire [7:0] clr_b = wr_hit(wr, paddr, `EIC_OFS_REQ_B) ? (~wd & `EIC_MSK_B) : 8'h00;
   wire [7:0] clr_c = wr_hit(wr, paddr, `EIC_OFS_REQ_C) ? ~wd : 8'h00;
   wire [7:0] set_a;
   wire [7:0] set_b;

   assign set_a = {tmr_b1_evt, tmr_a_evt, 2'b00, ext_set}; // R05 R14
   assign set_b = {dxfer_evt, adc_evt, 1'b0, serial_done_evt, 4'h0}; // R01 R14

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         req_a_q <= `EIC_RST_REQ_A;
         req_b_q <= `EIC_RST_ZERO;
         req_c_q <= `EIC_RST_ZERO; // R03
      end else begin
         // acceptance never touches the flags
         req_a_q <= ((req_a_q & ~clr_a) | set_a) | `EIC_RST_REQ_A; // R04
         req_b_q <= ((req_b_q & ~clr_b) | set_b) & `EIC_MSK_B; // R01 R02 R04
         req_c_q <= (req_c_q & ~clr_c) | grp_hit; // R03 R04
      end
   end

   // ------------------------------------------------------------
   // pending vector by number
   // ------------------------------------------------------------
   // vectors 14 to 23 stay free for peripherals not built here
   wire        grp_pend = |(req_c_q & en_c_q); // R08 R12
   wire [23:0] pend;

   assign pend = {10'h000,
                  req_a_q[`EIC_BIT_TMR_B1] & en_tmr_q[1],
                  req_a_q[`EIC_BIT_TMR_A]  & en_tmr_q[0],
                  req_b_q[`EIC_BIT_DXFER]  & en_b_q[`EIC_BIT_DXFER],
                  req_b_q[`EIC_BIT_ADC]    & en_b_q[`EIC_BIT_ADC],
                  req_b_q[`EIC_BIT_SER]    & en_b_q[`EIC_BIT_SER],
                  grp_pend,
                  req_a_q[3:0] & en_ext_q,
                  4'h0}; // R09 R11 R14
   wire        any_pend = |pend;
   wire [4:0]  sel_vec  = top_vec(pend); // R15
   wire        gmask    = ccr_q[`EIC_BIT_GMASK];
   // a bus access in flight finishes before acceptance is decided
   // trade-off: a busy register bus delays acceptance by a few states
   wire        can_take = any_pend & ~gmask & ~psel; // R10 R16 R21

   // ------------------------------------------------------------
   // condition code register
   // ------------------------------------------------------------
   wire exc_start = (state_q == S_WAIT) & instr_done & can_take;

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         ccr_q <= `EIC_RST_CCR;
      end else if (exc_start) begin
         ccr_q <= ccr_q | `EIC_RST_CCR; // R18
      end else if (wr_hit(wr, paddr, `EIC_OFS_CCR)) begin
         ccr_q <= wd;
      end
   end

   // ------------------------------------------------------------
   // exception sequencer
   // ------------------------------------------------------------
   // one state per clock; the instruction wait depends on the core
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         state_q        <= S_IDLE;
         cnt_q          <= 3'h0;
         vec_q          <= 5'h00;
         stack_pc_q     <= 16'h0000;
         stack_ccr_q    <= 8'h00;
         vec_addr_q     <= 16'h0000;
         handler_addr_q <= 16'h0000;
         handler_go_q   <= 1'b0;
      end else begin
         handler_go_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (can_take) begin
                  state_q <= S_WAIT; // R16
               end
            end
            S_WAIT: begin
               // re-decide at the boundary: a flag cleared meanwhile drops out
               if (instr_done) begin
                  if (can_take) begin
                     state_q     <= S_SAVE;
                     cnt_q       <= `EIC_ST_SAVE - 3'h1; // R22
                     vec_q       <= sel_vec; // R15
                     stack_pc_q  <= pc_next; // R17
                     stack_ccr_q <= ccr_q; // R17
                     vec_addr_q  <= {10'h000, sel_vec, 1'b0}; // R19
                  end else begin
                     state_q <= S_IDLE;
                  end
               end
            end
            S_SAVE: begin
               if (cnt_q == 3'h0) begin
                  state_q <= S_VEC;
                  cnt_q   <= `EIC_ST_VEC - 3'h1; // R22
               end else begin
                  cnt_q <= cnt_q - 3'h1;
               end
            end
            S_VEC: begin
               // vector word is taken on the last vector fetch state
               if (cnt_q == 3'h0) begin
                  state_q        <= S_FETCH;
                  cnt_q          <= `EIC_ST_FETCH - 3'h1; // R22
                  handler_addr_q <= vec_rd_data; // R19
               end else begin
                  cnt_q <= cnt_q - 3'h1;
               end
            end
            S_FETCH: begin
               if (cnt_q == 3'h0) begin
                  state_q <= S_INT;
                  cnt_q   <= `EIC_ST_INTERNAL - 3'h1; // R22
               end else begin
                  cnt_q <= cnt_q - 3'h1;
               end
            end
            S_INT: begin
               if (cnt_q == 3'h0) begin
                  state_q      <= S_IDLE;
                  handler_go_q <= 1'b1; // R19
               end else begin
                  cnt_q <= cnt_q - 3'h1;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // phase strobes to the core
   assign exc_busy      = (state_q != S_IDLE);
   assign stack_push    = (state_q == S_SAVE); // R17
   assign vec_fetch     = (state_q == S_VEC); // R19
   assign handler_fetch = (state_q == S_FETCH);

endmodule // eic_ctrl
`default_nettype wire
